/* File: src/serial_channel_defines.svh */
// Purpose: Named offsets, fields and counts of the serial channel
// Assumes: Included by bare name from the channel source
// Notes:   Register offsets are APB byte addresses
`ifndef SERIAL_CHANNEL_DEFINES_SVH
`define SERIAL_CHANNEL_DEFINES_SVH

// Register byte offsets
`define REG_DATA     8'h00
`define REG_MODE1    8'h04
`define REG_MODE2    8'h08
`define REG_STAT     8'h0c
`define REG_CMD      8'h10
`define REG_CSEL     8'h14
`define REG_PINSEL   8'h18
`define REG_LSET     8'h1c
`define REG_LCLR     8'h20
`define REG_IEN      8'h24

// Command bits
`define CMD_RX_EN    0
`define CMD_RX_DIS   1
`define CMD_TX_EN    2
`define CMD_TX_DIS   3
`define CMD_ERR_CLR  4

// First mode register fields
`define M1_RXRTS     7
`define M1_RXSEL     6
`define M1_PAR       4:3
`define M1_PTYPE     2
`define M1_BITS      1:0

// Second mode register fields
`define M2_CHMODE    7:6
`define M2_TXRTS     5
`define M2_STOP_HI   3
`define M2_STOP_LO   2:0

// Clock select fields
`define CS_RXSRC     1:0
`define CS_RX1X      2
`define CS_TXSRC     5:4
`define CS_TX1X      6

// Pin function select fields
`define PS_OP7       7
`define PS_OP6       6
`define PS_OP5       5
`define PS_OP4       4
`define PS_OP3       3:2
`define PS_OP2       1:0

// Interrupt enable bit
`define IEN_TX       0

// Encodings
`define PAR_WITH     2'b00
`define PAR_FORCE    2'b01
`define PAR_NONE     2'b10
`define PAR_MDROP    2'b11
`define CH_NORMAL    2'b00
`define CH_ECHO      2'b01
`define CH_LLOOP     2'b10
`define CH_RLOOP     2'b11
`define SRC_BAUD     2'b00
`define SRC_CT       2'b01
`define SRC_EXT      2'b10
`define FN_LATCH     2'b00
`define FN_ALT1      2'b01
`define FN_ALT2      2'b10
`define FN_ALT3      2'b11

// Counts and fixed values
`define OVS_FIRST    4'h1
`define OVS_SEVENTH  4'h6
`define OVS_LAST     4'hf
`define BIT16_LAST   5'h0f
`define BIT1_LAST    5'h00
`define HALF_DIV     3'h7
`define FIFO_DEPTH   2'h3
`define BREAK_CHAR   8'h00
`define MARK         1'b1
`define SPACE        1'b0
`define PINS_RESET   8'hff
`define PAD24        24'h00_0000

`endif

/* File: src/serial_channel_pkg.sv */
// Purpose: Types of the serial channel
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   The whole channel state is one packed struct
package serial_channel_pkg;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		tx_state_t;
	typedef enum logic [2:0]
		{RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} rx_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		apb_rsp_t       apb;
		logic [7:0]     mode1, mode2, csel, pinsel, latch, ien;
		logic           tx_en, rx_en;
		logic [7:0]     hold;
		logic           hold_v;
		tx_state_t      tst;
		logic [7:0]     tsh;
		logic [2:0]     tbit;
		logic [4:0]     tsub;
		logic           tpar, txd;
		rx_state_t      rst;
		logic [7:0]     rsh;
		logic [2:0]     rbit;
		logic [3:0]     rsub;
		logic           rpar, rperr, rall;
		logic [2:0][7:0] fifo;
		logic [1:0]     cnt;
		logic           f_brk, f_frm, f_par, f_ovr;
		logic           ext_prev, txc16, txc1, rxc1;
		logic [3:0]     tdiv, rdiv;
		logic           serial_out, irq;
		logic [7:0]     pins;
	} state_t;

endpackage

/* File: src/serial_channel.sv */
// Purpose: One asynchronous serial channel with APB registers
// Assumes: All inputs synchronous to CLK_IN; tick inputs are pulses
// Notes:   Bit clocks are enable pulses, never clocks
//
// Functional notes
// - Bits 7..4 pick latch or ready flags
// - Two-bit fields pick sources of pins 3, 2
// - Pins 0, 1 become RTS when enabled
// - Clock source and mode chosen independently
// - Normal, loop, echo and multidrop modes
// - Transmit holding stage is one-character FIFO
// - Written character moves to shifter, shifts out
// - Idle or disabled transmitter holds line high
// - One bit-period low start bit first
// - Data bits go out LSB first
// - Parity bit follows MSB, precedes stop
// - Interrupt when both transmit stages empty
// - Disable drains holding and shift stages
// - No writes accepted after disable
// - Received characters pass a three-deep FIFO
// - Data read pops FIFO head
// - Receiver idle while line marks
// - Start valid if low at seventh oversample
// - High at seventh sample means noise
// - Later bits sampled per period, mid-bit
// - Oversampling repeats on every start bit
// - Good character needs mark stop, valid parity
// - Receiver computes parity when enabled
// - Flags for frame, parity, overrun faults
// - Break flags, loads break, waits for mark
// - Two-bit field sets five to eight bits
//
// The APB register port and the register offsets are this design's own decisions.
`include "serial_channel_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_channel
	import serial_channel_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// Bit clock sources
	input  wire logic        BAUD_TICK_IN,
	input  wire logic        CT_TICK_IN,
	input  wire logic        EXT_CLK_IN,
	// Serial line
	input  wire logic        SERIAL_IN,
	output logic             SERIAL_OUT,
	// Other channel and counter/timer
	input  wire logic        CT_OUT_IN,
	input  wire logic        PEER_TX_READY_IN,
	input  wire logic        PEER_RX_READY_IN,
	input  wire logic        PEER_TXC_IN,
	input  wire logic        PEER_RXC_IN,
	input  wire logic        PEER_RTS_EN_IN,
	input  wire logic        PEER_RTS_N_IN,
	// Output port and transmit interrupt
	output logic      [7:0]  OUT_PIN_OUT,
	output logic             TX_IRQ_OUT
);

////////////////////////////////////////////////////////////////////////////
// Declarations

state_t      q;
state_t      n;
apb_req_t    req;
logic        setup;
logic        acc;
logic        hit;
logic [31:0] rdat;
logic        ext_tick;
logic        ttick;
logic        rtick;
logic        tx1x;
logic        rx1x;
logic        rin;
logic        rxon;
logic        smp;
logic        tend;
logic        load;
logic        pbit;
logic        push;
logic [7:0]  pval;
logic [4:0]  tlim;
logic [2:0]  nlast;
logic [1:0]  pmode;
logic        txempty;
logic        txrdy;
logic        full;
logic        rxrf;
logic        rts_on;
logic        p3;
logic        p2;

function automatic logic pick(input logic [1:0] src, input logic b,
	input logic c, input logic e);
	case (src)
		`SRC_BAUD: pick = b;
		`SRC_CT:   pick = c;
		`SRC_EXT:  pick = e;
		default:   pick = 1'b0;
	endcase
endfunction

assign req = '{psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN,
	paddr: PADDR_IN, pwdata: PWDATA_IN};

////////////////////////////////////////////////////////////////////////////
// Next state

always_comb
begin
	n = q;
	push = 1'b0;
	pval = `BREAK_CHAR;
	pmode = q.mode1[`M1_PAR];
	nlast = {1'b1, q.mode1[`M1_BITS]};
	setup = req.psel & ~req.penable;
	acc = req.psel & req.penable & q.apb.pready;
	ext_tick = EXT_CLK_IN & ~q.ext_prev;
	n.ext_prev = EXT_CLK_IN;
	// Each direction has its own source and rate
	tx1x = q.csel[`CS_TX1X];
	rx1x = q.csel[`CS_RX1X];
	ttick = pick(q.csel[`CS_TXSRC], BAUD_TICK_IN, CT_TICK_IN, ext_tick);
	rtick = pick(q.csel[`CS_RXSRC], BAUD_TICK_IN, CT_TICK_IN, ext_tick);

	// Register decode; answer in the first cycle of the access phase
	hit = 1'b1;
	rdat = '0;
	case (req.paddr)
		`REG_DATA:  rdat = {`PAD24, q.fifo[0]};
		`REG_MODE1: rdat = {`PAD24, q.mode1};
		`REG_MODE2: rdat = {`PAD24, q.mode2};
		`REG_STAT:  rdat = {`PAD24, q.f_brk, q.f_frm, q.f_par, q.f_ovr,
			~q.hold_v & (q.tst == TX_IDLE), ~q.hold_v & q.tx_en,
			q.cnt == `FIFO_DEPTH, q.cnt != '0};
		`REG_CSEL:  rdat = {`PAD24, q.csel};
		`REG_IEN:   rdat = {`PAD24, q.ien};
		`REG_CMD, `REG_PINSEL, `REG_LSET, `REG_LCLR: rdat = '0;
		default:    hit = 1'b0;
	endcase
	n.apb.pready = setup;
	if (setup)
	begin
		n.apb.prdata = rdat;
		n.apb.pslverr = ~hit;
	end

	if (acc && req.pwrite)
	begin
		case (req.paddr)
			`REG_MODE1:  n.mode1 = req.pwdata[7:0];
			`REG_MODE2:  n.mode2 = req.pwdata[7:0];
			`REG_CSEL:   n.csel = req.pwdata[7:0];
			`REG_PINSEL: n.pinsel = req.pwdata[7:0];
			`REG_LSET:   n.latch = q.latch | req.pwdata[7:0];
			`REG_LCLR:   n.latch = q.latch & ~req.pwdata[7:0];
			`REG_IEN:    n.ien = req.pwdata[7:0];
			`REG_CMD:
			begin
				if (req.pwdata[`CMD_RX_EN])
					n.rx_en = 1'b1;
				if (req.pwdata[`CMD_RX_DIS])
					n.rx_en = 1'b0;
				if (req.pwdata[`CMD_TX_EN])
					n.tx_en = 1'b1;
				// Stages keep draining; only new writes stop
				if (req.pwdata[`CMD_TX_DIS])
					n.tx_en = 1'b0;
				if (req.pwdata[`CMD_ERR_CLR])
				begin
					n.f_brk = 1'b0;
					n.f_frm = 1'b0;
					n.f_par = 1'b0;
					n.f_ovr = 1'b0;
				end
			end
			default: ;
		endcase
	end

	// Pop the head on a data read
	if (acc && !req.pwrite && req.paddr == `REG_DATA && q.cnt != '0)
	begin
		n.fifo[0] = q.fifo[1];
		n.fifo[1] = q.fifo[2];
		n.cnt = q.cnt - 2'h1;
	end

	////////////////////////////////////////////////////////////////////
	// Transmitter

	if (q.tst == TX_STOP)
		tlim = tx1x ? {4'h0, q.mode2[`M2_STOP_HI]} :
			{q.mode2[`M2_STOP_HI], 1'b1, q.mode2[`M2_STOP_LO]};
	else
		tlim = tx1x ? `BIT1_LAST : `BIT16_LAST;
	tend = ttick & (q.tsub == tlim) & (q.tst != TX_IDLE);
	load = q.hold_v & ((q.tst == TX_IDLE) | ((q.tst == TX_STOP) & tend));
	if (load)
	begin
		n.tsh = q.hold;
		n.hold_v = 1'b0;
		n.tst = TX_START;
		n.tsub = '0;
		n.tbit = '0;
		n.tpar = 1'b0;
	end
	else if (tend)
	begin
		n.tsub = '0;
		unique case (q.tst)
			TX_START: n.tst = TX_DATA;
			TX_DATA:
			begin
				n.tpar = q.tpar ^ q.tsh[0];
				n.tsh = q.tsh >> 1;
				if (q.tbit == nlast)
					n.tst = (pmode == `PAR_NONE) ? TX_STOP : TX_PAR;
				else
					n.tbit = q.tbit + 3'h1;
			end
			TX_PAR: n.tst = TX_STOP;
			TX_STOP, TX_IDLE: n.tst = TX_IDLE;
		endcase
	end
	else if (ttick && q.tst != TX_IDLE)
		n.tsub = q.tsub + 5'h01;

	// Holding stage refills in the cycle it empties
	if (acc && req.pwrite && req.paddr == `REG_DATA && q.tx_en
		&& !n.hold_v)
	begin
		n.hold = req.pwdata[7:0];
		n.hold_v = 1'b1;
	end

	// Multidrop sends the address/data flag in the parity slot
	pbit = (pmode == `PAR_WITH) ? n.tpar ^ q.mode1[`M1_PTYPE] :
		q.mode1[`M1_PTYPE];
	unique case (n.tst)
		TX_START: n.txd = `SPACE;
		TX_DATA:  n.txd = n.tsh[0];
		TX_PAR:   n.txd = pbit;
		TX_STOP, TX_IDLE: n.txd = `MARK;
	endcase

	unique case (q.mode2[`M2_CHMODE])
		`CH_NORMAL: n.serial_out = n.txd;
		`CH_LLOOP:  n.serial_out = `MARK;
		`CH_ECHO, `CH_RLOOP: n.serial_out = SERIAL_IN;
	endcase

	////////////////////////////////////////////////////////////////////
	// Receiver

	rin = (q.mode2[`M2_CHMODE] == `CH_LLOOP) ? q.txd : SERIAL_IN;
	rxon = q.rx_en & (q.mode2[`M2_CHMODE] != `CH_RLOOP);
	smp = rtick & (rx1x | (q.rsub == `OVS_LAST));
	if (rtick && (q.rst == RX_DATA || q.rst == RX_PAR || q.rst == RX_STOP))
		n.rsub = q.rsub + 4'h1;
	unique case (q.rst)
		RX_IDLE:
		begin
			// Mark level leaves the receiver parked
			if (rxon && rtick && rin == `SPACE)
			begin
				n.rall = 1'b1;
				n.rpar = 1'b0;
				n.rperr = 1'b0;
				n.rbit = '0;
				n.rsub = `OVS_FIRST;
				n.rst = rx1x ? RX_DATA : RX_START;
			end
		end
		RX_START:
		begin
			if (rtick)
			begin
				if (q.rsub == `OVS_SEVENTH)
				begin
					n.rsub = '0;
					n.rst = rin ? RX_IDLE : RX_DATA;
				end
				else
					n.rsub = q.rsub + 4'h1;
			end
		end
		RX_DATA:
		begin
			if (smp)
			begin
				n.rsh = {rin, q.rsh[7:1]};
				n.rpar = q.rpar ^ rin;
				n.rall = q.rall & ~rin;
				if (q.rbit == nlast)
					n.rst = (pmode == `PAR_NONE) ? RX_STOP : RX_PAR;
				else
					n.rbit = q.rbit + 3'h1;
			end
		end
		RX_PAR:
		begin
			if (smp)
			begin
				n.rperr = (pmode == `PAR_WITH) & (q.rpar ^ rin ^
					q.mode1[`M1_PTYPE]) | (pmode == `PAR_FORCE) &
					(rin ^ q.mode1[`M1_PTYPE]);
				n.rall = q.rall & ~rin;
				n.rst = RX_STOP;
			end
		end
		RX_STOP:
		begin
			if (smp)
			begin
				push = 1'b1;
				if (rin == `SPACE && q.rall)
				begin
					n.f_brk = 1'b1;
					n.rst = RX_BREAK;
				end
				else
				begin
					pval = q.rsh >> (~q.mode1[`M1_BITS]);
					n.f_frm = n.f_frm | ~rin;
					n.f_par = n.f_par | q.rperr;
					n.rst = RX_IDLE;
				end
			end
		end
		RX_BREAK:
			if (rin == `MARK)
				n.rst = RX_IDLE;
		default: n.rst = RX_IDLE;
	endcase

	// A character that finds the FIFO full is lost
	if (push)
	begin
		if (n.cnt == `FIFO_DEPTH)
			n.f_ovr = 1'b1;
		else
		begin
			n.fifo[n.cnt] = pval;
			n.cnt = n.cnt + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock outputs, flags, pins

	if (ttick)
	begin
		n.txc16 = ~q.txc16;
		n.tdiv = q.tdiv + 4'h1;
		if (tx1x || q.tdiv[2:0] == `HALF_DIV)
			n.txc1 = ~q.txc1;
	end
	if (rtick)
	begin
		n.rdiv = q.rdiv + 4'h1;
		if (rx1x || q.rdiv[2:0] == `HALF_DIV)
			n.rxc1 = ~q.rxc1;
	end

	txempty = ~n.hold_v & (n.tst == TX_IDLE);
	txrdy = ~n.hold_v & n.tx_en;
	full = n.cnt == `FIFO_DEPTH;
	rxrf = n.mode1[`M1_RXSEL] ? full : (n.cnt != '0);
	n.irq = n.ien[`IEN_TX] & txempty;

	// Flags are active low at the pins, like the latch
	n.pins[7] = ~(n.pinsel[`PS_OP7] ? PEER_TX_READY_IN : n.latch[7]);
	n.pins[6] = ~(n.pinsel[`PS_OP6] ? txrdy : n.latch[6]);
	n.pins[5] = ~(n.pinsel[`PS_OP5] ? PEER_RX_READY_IN : n.latch[5]);
	n.pins[4] = ~(n.pinsel[`PS_OP4] ? rxrf : n.latch[4]);
	unique case (n.pinsel[`PS_OP3])
		`FN_LATCH: p3 = ~n.latch[3];
		`FN_ALT1:  p3 = CT_OUT_IN;
		`FN_ALT2:  p3 = PEER_TXC_IN;
		`FN_ALT3:  p3 = PEER_RXC_IN;
	endcase
	unique case (n.pinsel[`PS_OP2])
		`FN_LATCH: p2 = ~n.latch[2];
		`FN_ALT1:  p2 = n.txc16;
		`FN_ALT2:  p2 = n.txc1;
		`FN_ALT3:  p2 = n.rxc1;
	endcase
	n.pins[3] = p3;
	n.pins[2] = p2;
	// Receiver drops RTS when full; transmitter once drained and off
	rts_on = n.latch[0] & ~(n.mode1[`M1_RXRTS] & full)
		& ~(n.mode2[`M2_TXRTS] & txempty & ~n.tx_en);
	if (n.mode1[`M1_RXRTS] || n.mode2[`M2_TXRTS])
		n.pins[0] = ~rts_on;
	else
		n.pins[0] = ~n.latch[0];
	n.pins[1] = PEER_RTS_EN_IN ? PEER_RTS_N_IN : ~n.latch[1];
end

////////////////////////////////////////////////////////////////////////////
// State register

always_ff @(posedge CLK_IN or negedge RST_N_IN)
begin
	if (!RST_N_IN)
	begin
		q <= '0;
		q.txd <= `MARK;
		q.serial_out <= `MARK;
		q.pins <= `PINS_RESET;
	end
	else
		q <= n;
end

assign PRDATA_OUT = q.apb.prdata;
assign PREADY_OUT = q.apb.pready;
assign PSLVERR_OUT = q.apb.pslverr;
assign SERIAL_OUT = q.serial_out;
assign OUT_PIN_OUT = q.pins;
assign TX_IRQ_OUT = q.irq;

endmodule // serial_channel

`default_nettype wire

/* File: verif/serial_channel_monitor.sv */
// Purpose: Port checker for the serial channel
// Assumes: Bound to the top module, one clock domain
// Notes:   Channel mode, pin, interrupt and transmit enable selects are shadowed from APB writes
`include "serial_channel_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_channel_monitor
	import serial_channel_pkg::*;
(
	// Clock and reset
	input wire logic        CLK_IN,
	input wire logic        RST_N_IN,
	// APB
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [7:0]  PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	// Line, pins and interrupt
	input wire logic        CT_OUT_IN,
	input wire logic        PEER_TX_READY_IN,
	input wire logic        SERIAL_OUT,
	input wire logic [7:0]  OUT_PIN_OUT,
	input wire logic        TX_IRQ_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	logic [7:0] sel_q;
	logic       ien_q;
	logic       on_q;
	logic [1:0] chm_q;
	logic       wr_done;

	assign wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;

	////////////////////////////////////////////////////////////////////////
	// Shadows of the selects; only the pin select and transmit enable cannot be read back
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sel_q <= 8'h00;
			ien_q <= 1'b0;
			on_q  <= 1'b0;
			chm_q <= `CH_NORMAL;
		end
		else if (wr_done)
		begin
			if (PADDR_IN == `REG_MODE2)
				chm_q <= PWDATA_IN[`M2_CHMODE];
			if (PADDR_IN == `REG_PINSEL)
				sel_q <= PWDATA_IN[7:0];
			if (PADDR_IN == `REG_IEN)
				ien_q <= PWDATA_IN[`IEN_TX];
			if (PADDR_IN == `REG_CMD && PWDATA_IN[`CMD_TX_EN])
				on_q <= 1'b1;
			if (PADDR_IN == `REG_CMD && PWDATA_IN[`CMD_TX_DIS])
				on_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence setup_s;
		PSEL_IN && !PENABLE_IN;
	endsequence

	// Load into an empty, enabled transmitter; loop modes mask the line
	sequence load_s;
		wr_done && PADDR_IN == `REG_DATA && on_q && TX_IRQ_OUT
			&& chm_q == `CH_NORMAL;
	endsequence

	ready_after_a: assert property (setup_s |=> PREADY_OUT)
		else $error("no ready after setup");
	ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	error_unmapped_a: assert property (setup_s ##0 PADDR_IN > `REG_IEN
		|=> PSLVERR_OUT && PREADY_OUT)
		else $error("unmapped access not refused");
	error_mapped_a: assert property (setup_s ##0
		(PADDR_IN <= `REG_IEN && PADDR_IN[1:0] == 2'h0) |=> !PSLVERR_OUT)
		else $error("mapped access refused");
	pin_ready_a: assert property (sel_q[7] |->
		OUT_PIN_OUT[7] == !$past(PEER_TX_READY_IN))
		else $error("pin 7 not routed from ready flag");
	pin_timer_a: assert property (sel_q[3:2] == 2'h1 |->
		OUT_PIN_OUT[3] == $past(CT_OUT_IN))
		else $error("pin 3 not routed from timer");
	irq_enable_a: assert property (TX_IRQ_OUT |-> ien_q)
		else $error("interrupt while not enabled");
	tx_start_a: assert property (load_s |-> ##[1:4] !SERIAL_OUT)
		else $error("no start bit after load");
	irq_clear_a: assert property (load_s |-> ##[1:3] !TX_IRQ_OUT)
		else $error("interrupt kept after load");
endmodule // serial_channel_monitor

bind serial_channel serial_channel_monitor mon_u (
	.CLK_IN,
	.RST_N_IN,
	.PSEL_IN,
	.PENABLE_IN,
	.PWRITE_IN,
	.PADDR_IN,
	.PWDATA_IN,
	.PREADY_OUT,
	.PSLVERR_OUT,
	.CT_OUT_IN,
	.PEER_TX_READY_IN,
	.SERIAL_OUT,
	.OUT_PIN_OUT,
	.TX_IRQ_OUT
);

`default_nettype wire

/* File: verif/remote_station.sv */
// Purpose: Remote asynchronous station on the serial line
// Assumes: Bit period is a whole number of clock cycles
// Notes:   Line rests at mark between frames, like a pull-up
`timescale 1ns/100ps
`default_nettype none

module remote_station #(
	parameter int BIT = 32
)(
	// Clock
	input  wire logic CLK_IN,
	// Serial line
	input  wire logic LINE_IN,
	output var logic  LINE_OUT
);
	initial LINE_OUT = 1'b1;

	task automatic put(input logic v);
		LINE_OUT <= v;
		repeat (BIT) @(posedge CLK_IN);
	endtask

	task automatic send(input logic [7:0] d, input int nb, input logic pe,
		input logic pv, input logic sv);
		int i;
		@(posedge CLK_IN);
		put(1'b0);
		for (i = 0; i < nb; i++)
			put(d[i]);
		if (pe)
			put(pv);
		put(sv);
		LINE_OUT <= 1'b1;
	endtask

	// Too short to survive the start check
	task automatic glitch();
		@(posedge CLK_IN);
		LINE_OUT <= 1'b0;
		repeat (5) @(posedge CLK_IN);
		LINE_OUT <= 1'b1;
	endtask

	// Samples mid-bit; gives up if no start within 400 cycles
	task automatic recv(input logic pe, output logic [7:0] d,
		output logic p, output logic s, output logic ok);
		int n;
		ok = 1'b0;
		p = 1'b1;
		for (n = 0; n < 400 && LINE_IN; n++)
			@(posedge CLK_IN);
		if (!LINE_IN)
		begin
			ok = 1'b1;
			repeat (BIT / 2) @(posedge CLK_IN);
			for (n = 0; n < 9 + pe; n++)
			begin
				repeat (BIT) @(posedge CLK_IN);
				if (n < 8)
					d[n] = LINE_IN;
				else if (pe && n == 8)
					p = LINE_IN;
				s = LINE_IN;
			end
		end
	endtask
endmodule // remote_station

`default_nettype wire

/* File: verif/dual_async_serial_channel_tb.sv */
// Purpose: Self-checking bench of the serial channel
// Assumes: Baud tick every other cycle, 16x, so 32 cycles a bit
// Notes:   Counter/timer and external ticks stay idle
`include "serial_channel_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_async_serial_channel_tb;
	import serial_channel_pkg::*;

	logic        clk_in = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        baud = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic        pready, perr, er, sout, sin, irq, p, s, ok;
	logic [7:0]  pins, d;
	logic [6:0]  peer = 7'h64;
	int          mismatches = 0;
	int          compares = 0;
	int          i;

	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) baud <= ~baud;

	serial_channel dut_u (
		.CLK_IN(clk_in), .RST_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .BAUD_TICK_IN(baud), .CT_TICK_IN(1'b0),
		.EXT_CLK_IN(1'b0), .SERIAL_IN(sin), .SERIAL_OUT(sout),
		.CT_OUT_IN(peer[6]), .PEER_TX_READY_IN(peer[5]),
		.PEER_RX_READY_IN(peer[4]), .PEER_TXC_IN(peer[3]),
		.PEER_RXC_IN(peer[2]), .PEER_RTS_EN_IN(peer[1]),
		.PEER_RTS_N_IN(peer[0]), .OUT_PIN_OUT(pins), .TX_IRQ_OUT(irq));

	remote_station #(.BIT(32)) rem_u (
		.CLK_IN(clk_in), .LINE_IN(sout), .LINE_OUT(sin));

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			mismatches++;
		end
	endtask

	// Holds the request until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_in);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			mismatches++;
			wrap_up();
		end
		r = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_in);
		mismatches++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_n <= 1'b1;
		@(negedge clk_in);
		chk({sout, irq, pins}, 32'h0000_02ff);
		apb(1'b1, `REG_LSET, 32'h0000_0009);
		repeat (2) @(negedge clk_in);
		chk(pins, 32'h0000_00f6);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, `REG_PINSEL, 32'h0000_00a0 | 32'(i << 2));
			repeat (2) @(negedge clk_in);
			chk(pins & 8'ha8, 8'h20 | {4'h0, 4'ha >> i & 4'h1, 3'h0});
		end
		@(posedge clk_in);
		peer <= 7'h66;
		repeat (2) @(negedge clk_in);
		chk(pins[1], 1'b0);
		apb(1'b1, `REG_MODE1, 32'h0000_0013);
		apb(1'b1, `REG_MODE2, 32'h0000_0007);
		apb(1'b1, `REG_IEN, 32'h0000_0001);
		apb(1'b1, `REG_CMD, 32'h0000_0005);
		repeat (3) @(negedge clk_in);
		chk(irq, 1'b1);
		fork
			rem_u.recv(1'b0, d, p, s, ok);
			apb(1'b1, `REG_DATA, 32'h0000_005d);
		join
		chk({ok, s, d}, 32'h0000_035d);
		apb(1'b1, `REG_MODE1, 32'h0000_0003);
		fork
			rem_u.recv(1'b1, d, p, s, ok);
			apb(1'b1, `REG_DATA, 32'h0000_005d);
		join
		chk({ok, p, s, d}, 32'h0000_075d);
		apb(1'b1, `REG_MODE1, 32'h0000_0013);
		fork
			begin
				rem_u.recv(1'b0, d, p, s, ok);
				chk({ok, d}, 32'h0000_01a1);
				rem_u.recv(1'b0, d, p, s, ok);
				chk({ok, d}, 32'h0000_01b2);
				rem_u.recv(1'b0, d, p, s, ok);
				chk(ok, 1'b0);
			end
			begin
				apb(1'b1, `REG_DATA, 32'h0000_00a1);
				// Second write only once the first has moved on
				repeat (40) @(posedge clk_in);
				apb(1'b1, `REG_DATA, 32'h0000_00b2);
				apb(1'b1, `REG_CMD, 32'h0000_0008);
				// Holding stage empty again, so only disable refuses
				repeat (320) @(posedge clk_in);
				apb(1'b1, `REG_DATA, 32'h0000_00c3);
			end
		join
		chk(sout, 1'b1);
		apb(1'b1, `REG_MODE1, 32'h0000_0093);
		for (i = 1; i < 4; i++)
			rem_u.send(8'h11 * i, 8, 1'b0, 1'b0, 1'b1);
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk({pins[0], r[7:0] & 8'hf3}, 32'h0000_0103);
		rem_u.send(8'h44, 8, 1'b0, 1'b0, 1'b1);
		for (i = 1; i < 4; i++)
		begin
			apb(1'b0, `REG_DATA, 32'h0000_0000);
			chk(r, 32'h0000_0011 * i);
		end
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk({pins[0], r[7:0] & 8'h13}, 32'h0000_0010);
		apb(1'b1, `REG_CMD, 32'h0000_0010);
		rem_u.glitch();
		repeat (400) @(negedge clk_in);
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk(r[0], 1'b0);
		rem_u.send(8'h55, 8, 1'b0, 1'b0, 1'b0);
		// Low stop tail may start one more character; let it finish
		repeat (400) @(posedge clk_in);
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk(r[6], 1'b1);
		for (i = 0; i < 3; i++)
			apb(1'b0, `REG_DATA, 32'h0000_0000);
		rem_u.send(8'h00, 8, 1'b0, 1'b0, 1'b0);
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk(r[7], 1'b1);
		apb(1'b0, `REG_DATA, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b1, `REG_CMD, 32'h0000_0010);
		apb(1'b1, `REG_MODE1, 32'h0000_0003);
		rem_u.send(8'h5d, 8, 1'b1, 1'b1, 1'b1);
		apb(1'b0, `REG_DATA, 32'h0000_0000);
		chk(r, 32'h0000_005d);
		rem_u.send(8'h5d, 8, 1'b1, 1'b0, 1'b1);
		apb(1'b0, `REG_STAT, 32'h0000_0000);
		chk(r[5], 1'b1);
		apb(1'b0, `REG_DATA, 32'h0000_0000);
		apb(1'b1, `REG_MODE1, 32'h0000_0010);
		rem_u.send(8'h35, 5, 1'b0, 1'b0, 1'b1);
		apb(1'b0, `REG_DATA, 32'h0000_0000);
		chk(r, 32'h0000_0015);
		apb(1'b1, `REG_MODE2, 32'h0000_0087);
		apb(1'b1, `REG_CMD, 32'h0000_0004);
		apb(1'b1, `REG_DATA, 32'h0000_003c);
		repeat (100) @(posedge clk_in);
		chk(sout, 1'b1);
		repeat (300) @(posedge clk_in);
		apb(1'b0, `REG_DATA, 32'h0000_0000);
		chk(r, 32'h0000_001c);
		apb(1'b0, `REG_PINSEL, 32'h0000_0000);
		chk({er, r[30:0]}, 32'h0000_0000);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk(er, 1'b1);
		wrap_up();
	end
endmodule // dual_async_serial_channel_tb

`default_nettype wire
